// ---- core/rps_pkg.sv ----
/*
  Shared constants, types and delay tables for the regulator power sequencer.
  Assumes a 100 MHz core clock and an APB master with 32-bit data.
*/
package rps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEGLITCH_NS = 1_000_000;
  localparam int DEGLITCH_CYCLES = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_MS_NS = 500_000;
  localparam int HALF_MS_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;
  localparam int SS_STEP_NS = 20_000;
  localparam int SS_STEP_CYCLES = (SS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_FREQ_KHZ = 2_100;
  localparam int SW_DIV_CYCLES = 1_000_000 / (SW_FREQ_KHZ * CLK_PERIOD_NS);
  localparam int SKIP_ENTRY_TICKS = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] ON_DELAY_OFS = 12'h004;
  localparam logic [11:0] OFF_DELAY_OFS = 12'h008;
  localparam logic [11:0] VOUT_OFS = 12'h00C;
  localparam logic [11:0] STATUS_OFS = 12'h010;
  localparam int CTRL_SI_EN_POS = 0;
  localparam int CTRL_FORCE_POS = 4;
  localparam int VOUT_B1_POS = 0;
  localparam int VOUT_B2_POS = 8;
  localparam int ST_ON_POS = 0;
  localparam int ST_SKIP_POS = 4;
  localparam int ST_BUSY_POS = 6;
  localparam int ST_TRIG_POS = 7;
  localparam int ST_VIN_POS = 8;
  localparam int ST_ACTIVE_POS = 9;
  localparam logic [15:0] DLY_MASK = 16'h7777;
  localparam logic [3:0] SI_EN_RST = 4'hF;
  localparam logic [1:0] FORCE_RST = 2'h0;
  localparam logic [15:0] ON_CODE_RST = 16'h4321;
  localparam logic [15:0] OFF_CODE_RST = 16'h7777;
  localparam logic [5:0] VOUT1_RST = 6'h08;
  localparam logic [5:0] VOUT2_RST = 6'h10;

  ////////////////////////////////////////////////////////////////////////////
  // current limits in mA
  localparam logic [1:0] ILIM_FULL = 2'h3;
  localparam logic [10:0] B1_MA0 = 11'h0B4;
  localparam logic [10:0] B1_MA1 = 11'h12C;
  localparam logic [10:0] B1_MA2 = 11'h2D0;
  localparam logic [10:0] B1_MAF = 11'h5DC;
  localparam logic [10:0] B2_MA0 = 11'h0A1;
  localparam logic [10:0] B2_MA1 = 11'h12C;
  localparam logic [10:0] B2_MA2 = 11'h218;
  localparam logic [10:0] B2_MAF = 11'h3E8;

  typedef struct packed {
    logic pwm_high;
    logic vout_low;
    logic vout_high;
    logic vout_low2;
    logic peak_limit;
    logic zero_current;
    logic discontinuous;
    logic below_mode;
  } rps_sense_s;

  typedef enum logic [1:0] {SEQ_STANDBY, SEQ_POWER_UP, SEQ_ACTIVE, SEQ_POWER_DOWN} rps_seq_e;
  typedef enum logic [2:0] {BK_OFF, BK_FIXED, BK_SLEEP, BK_SKIP_HS, BK_SKIP_LS} rps_buck_e;

  // delays in half-millisecond ticks
  function automatic logic [4:0] rps_on_half(input logic [2:0] code);
    case (code)
      3'h0: rps_on_half = 5'h02;
      3'h1: rps_on_half = 5'h03;
      3'h2: rps_on_half = 5'h04;
      3'h3: rps_on_half = 5'h06;
      3'h4: rps_on_half = 5'h0C;
      default: rps_on_half = 5'h16;
    endcase
  endfunction : rps_on_half

  // codes 6 and 7 follow the power-on delay of the same regulator
  function automatic logic [4:0] rps_off_half(input logic [2:0] code, input logic [2:0] on);
    case (code)
      3'h0: rps_off_half = 5'h00;
      3'h1: rps_off_half = 5'h01;
      3'h2: rps_off_half = 5'h02;
      3'h3: rps_off_half = 5'h04;
      3'h4: rps_off_half = 5'h0A;
      3'h5: rps_off_half = 5'h14;
      default: rps_off_half = rps_on_half(on);
    endcase
  endfunction : rps_off_half

endpackage : rps_pkg

// ---- core/rps_deglitch.sv ----
/*
  Deglitch filter for the sequence trigger pin: an edge counts only once the
  new level has held for LEN clocks. Assumes the pin is synchronous.
*/
`timescale 1ns/1ps
module rps_deglitch
  import rps_pkg::*;
#(
  parameter int LEN = DEGLITCH_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic raw,
  output logic level,
  output logic rise,
  output logic fall
);

  localparam logic [16:0] LAST = 17'(LEN - 1);
  logic [16:0] cnt;
  wire differs = raw != level;
  wire qualified = differs && cnt == LAST;

  // pin defaults low, so the filter starts low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
      cnt <= 17'h00000;
    end else begin
      rise <= qualified && raw;
      fall <= qualified && !raw;
      if (qualified) begin
        level <= raw;
      end
      cnt <= (differs && !qualified) ? cnt + 17'h00001 : 17'h00000;
    end
  end

  property p_deglitch;
    @(posedge clk) disable iff (!rst_n)
      $changed(level) |-> $past(cnt) == LAST && $past(raw) == level;
  endproperty
  a_deglitch: assert property (p_deglitch) else $error("edge taken before hold time");

endmodule : rps_deglitch

// ---- core/rps_buck_ctrl.sv ----
/*
  Digital control of one buck: shutdown, fixed-frequency and pulse-skipping
  switch control, automatic mode change and soft-start current-limit steps.
  Assumes comparator and modulator inputs synchronous to clk, and one
  switching-clock pulse on sw_tick.
*/
`timescale 1ns/1ps
module rps_buck_ctrl
  import rps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sw_tick,
  input wire logic enable,
  input wire logic vin_ok,
  input wire logic force_fixed,
  input wire rps_sense_s sense,
  output logic hs_on,
  output logic ls_on,
  output logic skip_mode,
  output logic [1:0] ilim_step
);

  localparam logic [4:0] P_LAST = 5'(SKIP_ENTRY_TICKS - 1);
  localparam logic [10:0] SS_LAST = 11'(SS_STEP_CYCLES - 1);

  rps_buck_e state, next_state;
  logic [4:0] persist;
  logic [10:0] ss_cnt;
  logic en_q;

  wire entry_cond = sense.discontinuous || sense.below_mode;
  wire skip_go = sw_tick && entry_cond && persist == P_LAST && !force_fixed;
  wire in_skip = state == BK_SLEEP || state == BK_SKIP_HS || state == BK_SKIP_LS;
  wire ss_start = enable && !en_q && vin_ok;

  always_comb begin
    next_state = state;
    case (state)
      BK_OFF: if (enable) next_state = BK_FIXED;
      BK_FIXED: if (skip_go) next_state = BK_SLEEP;
      BK_SLEEP: if (sense.vout_low) next_state = BK_SKIP_HS;
      BK_SKIP_HS: if (sense.vout_high || sense.peak_limit) next_state = BK_SKIP_LS;
      BK_SKIP_LS: begin
        if (sense.zero_current) begin
          next_state = sense.vout_high ? BK_SLEEP : BK_SKIP_HS;
        end
      end
      default: next_state = BK_OFF;
    endcase
    if (in_skip && (force_fixed || sense.vout_low2)) begin
      next_state = BK_FIXED;
    end
    if (!enable) begin
      next_state = BK_OFF;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= BK_OFF;
      hs_on <= 1'b0;
      ls_on <= 1'b1;
      skip_mode <= 1'b0;
      en_q <= 1'b0;
    end else begin
      state <= next_state;
      en_q <= enable;
      hs_on <= next_state == BK_SKIP_HS || (next_state == BK_FIXED && sense.pwm_high);
      // low side discharges the output in shutdown
      ls_on <= next_state == BK_OFF || next_state == BK_SKIP_LS ||
               (next_state == BK_FIXED && !sense.pwm_high);
      skip_mode <= next_state == BK_SLEEP || next_state == BK_SKIP_HS ||
                   next_state == BK_SKIP_LS;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      persist <= 5'h00;
    end else if (state != BK_FIXED || !entry_cond || force_fixed) begin
      persist <= 5'h00;
    end else if (sw_tick && persist != P_LAST) begin
      persist <= persist + 5'h01;
    end
  end

  // a restart without a fresh enable edge keeps the full limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ilim_step <= ILIM_FULL;
      ss_cnt <= 11'h000;
    end else if (ss_start) begin
      ilim_step <= 2'h0;
      ss_cnt <= 11'h000;
    end else if (ilim_step != ILIM_FULL) begin
      ss_cnt <= (ss_cnt == SS_LAST) ? 11'h000 : ss_cnt + 11'h001;
      if (ss_cnt == SS_LAST) ilim_step <= ilim_step + 2'h1;
    end
  end

  property p_entry;
    @(posedge clk) disable iff (!rst_n) $rose(skip_mode) |-> $past(persist) == P_LAST;
  endproperty
  a_entry: assert property (p_entry) else $error("skip entered too early");
  property p_force;
    @(posedge clk) disable iff (!rst_n) force_fixed && enable |=> !skip_mode;
  endproperty
  a_force: assert property (p_force) else $error("forced buck in skip mode");
  property p_low2;
    @(posedge clk) disable iff (!rst_n) skip_mode && sense.vout_low2 |=> !skip_mode;
  endproperty
  a_low2: assert property (p_low2) else $error("no exit on low2");
  property p_shut;
    @(posedge clk) disable iff (!rst_n) !enable |=> ls_on && !hs_on && !skip_mode;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown switches wrong");
  property p_wake;
    @(posedge clk) disable iff (!rst_n)
      state == BK_SLEEP && sense.vout_low && enable && !force_fixed && !sense.vout_low2
      |=> hs_on;
  endproperty
  a_wake: assert property (p_wake) else $error("high side not on at low");
  property p_ss;
    @(posedge clk) disable iff (!rst_n)
      $changed(ilim_step) && ilim_step != 2'h0 |-> $past(ss_cnt) == SS_LAST;
  endproperty
  a_ss: assert property (p_ss) else $error("soft-start step timing");
  property p_ss_go;
    @(posedge clk) disable iff (!rst_n) $fell(ilim_step == ILIM_FULL) |-> $past(ss_start);
  endproperty
  a_ss_go: assert property (p_ss_go) else $error("soft start without edge");
  c_skip: cover property (@(posedge clk) disable iff (!rst_n) state == BK_SKIP_LS);

endmodule : rps_buck_ctrl

// ---- core/rps_sequencer.sv ----
/*
  Power sequencer top: trigger deglitch, timed power-on and power-off,
  regulator enable gating, buck control and an APB register slave.
  Assumes all pins synchronous to CLOCK and an APB master as in APB3.
*/
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module rps_sequencer
  import rps_pkg::*;
#(
  parameter int DEGLITCH_LEN = DEGLITCH_CYCLES,
  parameter int HALF_MS_LEN = HALF_MS_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SEQ_TRIGGER,
  input wire logic BUCK1_PIN_ENABLE,
  input wire logic BUCK2_PIN_ENABLE,
  input wire logic LINREG1_PIN_ENABLE,
  input wire logic LINREG2_PIN_ENABLE,
  input wire logic VIN_OK,
  input wire rps_sense_s BUCK1_SENSE,
  input wire rps_sense_s BUCK2_SENSE,
  output logic [3:0] REG_ON,
  output logic BUCK1_HS_ON,
  output logic BUCK1_LS_ON,
  output logic BUCK2_HS_ON,
  output logic BUCK2_LS_ON,
  output logic [1:0] SKIP_MODE,
  output logic [10:0] BUCK1_ILIMIT_MA,
  output logic [10:0] BUCK2_ILIMIT_MA,
  output logic [5:0] BUCK1_VOUT,
  output logic [5:0] BUCK2_VOUT
);

  localparam logic [15:0] HALF_LAST = 16'(HALF_MS_LEN - 1);
  localparam logic [5:0] SW_LAST = 6'(SW_DIV_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // trigger filter
  logic trig_level;
  logic trig_rise;
  logic trig_fall;

  rps_deglitch #(
    .LEN(DEGLITCH_LEN)
  ) u_deglitch (
    .clk(CLOCK),
    .rst_n(RESETN),
    .raw(SEQ_TRIGGER),
    .level(trig_level),
    .rise(trig_rise),
    .fall(trig_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0] si_en;
  logic [1:0] force_fixed;
  logic [15:0] on_code;
  logic [15:0] off_code;
  rps_seq_e state, next_state;
  logic [3:0] seq_on;
  logic [4:0] elapsed;
  logic [15:0] half_div;
  logic [5:0] sw_div;
  logic [1:0] hs;
  logic [1:0] ls;
  logic [1:0] skip;
  logic [1:0] ilim [2];

  wire setup = PSEL && !PENABLE;
  wire access = PSEL && PENABLE && PREADY;
  wire wr = access && PWRITE;
  wire hit_ctrl = PADDR == CTRL_OFS;
  wire hit_on = PADDR == ON_DELAY_OFS;
  wire hit_off = PADDR == OFF_DELAY_OFS;
  wire hit_vout = PADDR == VOUT_OFS;
  wire hit_status = PADDR == STATUS_OFS;
  wire mapped = hit_ctrl || hit_on || hit_off || hit_vout || hit_status;
  wire entering_active = state != SEQ_ACTIVE && next_state == SEQ_ACTIVE;

  wire [31:0] rd_ctrl = {26'h0000000, force_fixed, si_en};
  wire [31:0] rd_vout = {16'h0000, 2'h0, BUCK2_VOUT, 2'h0, BUCK1_VOUT};
  wire [31:0] rd_status = {22'h000000, state == SEQ_ACTIVE, VIN_OK, trig_level,
                           state == SEQ_POWER_UP || state == SEQ_POWER_DOWN,
                           SKIP_MODE, REG_ON};
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                       hit_on ? {16'h0000, on_code} :
                       hit_off ? {16'h0000, off_code} :
                       hit_vout ? rd_vout :
                       hit_status ? rd_status : 32'h00000000;

  // zero-wait slave: ready is raised for the first access cycle
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !mapped;
      if (setup) PRDATA <= rd_mux;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      si_en <= SI_EN_RST;
      force_fixed <= FORCE_RST;
      on_code <= ON_CODE_RST;
      off_code <= OFF_CODE_RST;
    end else begin
      if (wr && hit_ctrl) begin
        si_en <= PWDATA[CTRL_SI_EN_POS +: 4];
        force_fixed <= PWDATA[CTRL_FORCE_POS +: 2];
      end
      // the sequencer's own buck enable wins over a write in that cycle
      if (entering_active) si_en[1:0] <= 2'h3;
      if (wr && hit_on) on_code <= PWDATA[15:0] & DLY_MASK;
      if (wr && hit_off) off_code <= PWDATA[15:0] & DLY_MASK;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      BUCK1_VOUT <= VOUT1_RST;
      BUCK2_VOUT <= VOUT2_RST;
    end else if (entering_active) begin
      BUCK1_VOUT <= VOUT1_RST;
      BUCK2_VOUT <= VOUT2_RST;
    end else if (wr && hit_vout) begin
      BUCK1_VOUT <= PWDATA[VOUT_B1_POS +: 6];
      BUCK2_VOUT <= PWDATA[VOUT_B2_POS +: 6];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  logic [4:0] on_half [4];
  logic [4:0] off_half [4];
  logic [3:0] up_due;
  logic [3:0] down_due;

  for (genvar i = 0; i < 4; i++) begin : g_dly
    assign on_half[i] = rps_on_half(on_code[4*i +: 3]);
    assign off_half[i] = rps_off_half(off_code[4*i +: 3], on_code[4*i +: 3]);
    assign up_due[i] = elapsed >= on_half[i];
    assign down_due[i] = elapsed >= off_half[i];
  end

  wire edge_seen = trig_rise || trig_fall;
  wire half_tick = half_div == HALF_LAST;

  always_comb begin
    next_state = state;
    case (state)
      SEQ_STANDBY: if (trig_rise) next_state = SEQ_POWER_UP;
      SEQ_POWER_UP: begin
        if (trig_fall) next_state = SEQ_POWER_DOWN;
        else if (&up_due) next_state = SEQ_ACTIVE;
      end
      SEQ_ACTIVE: if (trig_fall) next_state = SEQ_POWER_DOWN;
      SEQ_POWER_DOWN: begin
        if (trig_rise) next_state = SEQ_POWER_UP;
        else if (&down_due) next_state = SEQ_STANDBY;
      end
      default: next_state = SEQ_STANDBY;
    endcase
  end

  // one timebase, restarted at every qualified edge
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state <= SEQ_STANDBY;
      half_div <= 16'h0000;
      elapsed <= 5'h00;
    end else begin
      state <= next_state;
      if (edge_seen) begin
        half_div <= 16'h0000;
        elapsed <= 5'h00;
      end else begin
        half_div <= half_tick ? 16'h0000 : half_div + 16'h0001;
        if (half_tick && elapsed != 5'h1F) elapsed <= elapsed + 5'h01;
      end
    end
  end

  // regulators already up at an abort stay up until their off delay
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      seq_on <= 4'h0;
    end else if (state == SEQ_POWER_UP && !edge_seen) begin
      seq_on <= seq_on | up_due;
    end else if (state == SEQ_POWER_DOWN && !edge_seen) begin
      seq_on <= seq_on & ~down_due;
    end
  end

  wire [3:0] pin_en = {LINREG2_PIN_ENABLE, LINREG1_PIN_ENABLE,
                       BUCK2_PIN_ENABLE, BUCK1_PIN_ENABLE};
  // a held trigger keeps seq_on set, which masks the pins
  wire [3:0] next_reg_on = {4{VIN_OK}} & si_en & (pin_en | seq_on);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      REG_ON <= 4'h0;
      sw_div <= 6'h00;
      BUCK1_ILIMIT_MA <= B1_MAF;
      BUCK2_ILIMIT_MA <= B2_MAF;
    end else begin
      REG_ON <= next_reg_on;
      sw_div <= (sw_div == SW_LAST) ? 6'h00 : sw_div + 6'h01;
      BUCK1_ILIMIT_MA <= ilim[0] == 2'h0 ? B1_MA0 : ilim[0] == 2'h1 ? B1_MA1 :
                         ilim[0] == 2'h2 ? B1_MA2 : B1_MAF;
      BUCK2_ILIMIT_MA <= ilim[1] == 2'h0 ? B2_MA0 : ilim[1] == 2'h1 ? B2_MA1 :
                         ilim[1] == 2'h2 ? B2_MA2 : B2_MAF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buck control
  rps_sense_s sense [2];
  assign sense[0] = BUCK1_SENSE;
  assign sense[1] = BUCK2_SENSE;

  for (genvar b = 0; b < 2; b++) begin : g_buck
    rps_buck_ctrl u_buck (
      .clk(CLOCK),
      .rst_n(RESETN),
      .sw_tick(sw_div == SW_LAST),
      .enable(REG_ON[b]),
      .vin_ok(VIN_OK),
      .force_fixed(force_fixed[b]),
      .sense(sense[b]),
      .hs_on(hs[b]),
      .ls_on(ls[b]),
      .skip_mode(skip[b]),
      .ilim_step(ilim[b])
    );
  end

  assign BUCK1_HS_ON = hs[0];
  assign BUCK1_LS_ON = ls[0];
  assign BUCK2_HS_ON = hs[1];
  assign BUCK2_LS_ON = ls[1];
  assign SKIP_MODE = skip;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_uvlo;
    @(posedge CLOCK) disable iff (!RESETN) !VIN_OK |=> REG_ON == 4'h0;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("regulator on in undervoltage");
  property p_hold;
    @(posedge CLOCK) disable iff (!RESETN)
      state == SEQ_ACTIVE && VIN_OK |=> REG_ON == $past(si_en);
  endproperty
  a_hold: assert property (p_hold) else $error("active outputs follow pins");
  property p_gate;
    @(posedge CLOCK) disable iff (!RESETN)
      VIN_OK ##1 VIN_OK |-> REG_ON == ($past(si_en) & ($past(pin_en) | $past(seq_on)));
  endproperty
  a_gate: assert property (p_gate) else $error("enable equation broken");
  property p_rise;
    @(posedge CLOCK) disable iff (!RESETN)
      trig_rise |=> state == SEQ_POWER_UP && elapsed == 5'h00;
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");
  property p_fall;
    @(posedge CLOCK) disable iff (!RESETN)
      trig_fall && state != SEQ_STANDBY |=> state == SEQ_POWER_DOWN;
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");
  property p_on_dly;
    @(posedge CLOCK) disable iff (!RESETN)
      $rose(seq_on[0]) |-> $past(elapsed) >= $past(on_half[0]) && $past(state) == SEQ_POWER_UP;
  endproperty
  a_on_dly: assert property (p_on_dly) else $error("buck 1 on early");
  property p_off_dly;
    @(posedge CLOCK) disable iff (!RESETN)
      $fell(seq_on[3]) |-> $past(elapsed) >= $past(off_half[3]);
  endproperty
  a_off_dly: assert property (p_off_dly) else $error("linreg 2 off early");
  property p_active;
    @(posedge CLOCK) disable iff (!RESETN)
      entering_active |=> si_en[1:0] == 2'h3 && BUCK1_VOUT == VOUT1_RST && BUCK2_VOUT == VOUT2_RST;
  endproperty
  a_active: assert property (p_active) else $error("active entry not applied");
  c_up: cover property (@(posedge CLOCK) disable iff (!RESETN) entering_active);
  c_down: cover property (@(posedge CLOCK) disable iff (!RESETN)
    state == SEQ_POWER_DOWN ##1 state == SEQ_STANDBY);
  c_abort: cover property (@(posedge CLOCK) disable iff (!RESETN)
    state == SEQ_POWER_UP && trig_fall);
  c_skip: cover property (@(posedge CLOCK) disable iff (!RESETN) $rose(SKIP_MODE[0]));

endmodule : rps_sequencer

// ---- testbench/rps_host_model.sv ----
/*
  Host-side model: drives the four regulator pin enables of the sequencer.
  Assumes the bench gives the wanted pin levels and the supply status.
*/
`timescale 1ns/1ps
module rps_host_model (
  input wire logic vin_ok,
  input wire logic [3:0] want,
  output logic [3:0] pins
);
  // host holds the converters off while the supply is low
  assign pins = vin_ok ? want : 4'h0;
endmodule : rps_host_model

// ---- testbench/tb_top.sv ----
/*
  Bench for the sequencer: APB reads scored from a queue, pin and trigger
  scenarios timed on REG_ON. Assumes shortened deglitch and half-ms counts.
*/
`timescale 1ns/1ps
module tb_top
  import rps_pkg::*;
;
  localparam int L = 20;
  localparam int H = 10;
  logic CLOCK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, SEQ_TRIGGER = 0;
  logic VIN_OK = 1, PREADY, PSLVERR;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA;
  logic [3:0] want = '0, pins, REG_ON, en, pv;
  logic [32:0] expq[$];
  logic hs1, ls1;
  logic [1:0] skip;
  logic [10:0] lim1, lim2;
  rps_sense_s sns = '0;
  int errors = 0, checks_done = 0, seed = 32'h187C;

  rps_sequencer #(.DEGLITCH_LEN(L), .HALF_MS_LEN(H)) DUT (
    .CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SEQ_TRIGGER(SEQ_TRIGGER), .BUCK1_PIN_ENABLE(pins[0]), .BUCK2_PIN_ENABLE(pins[1]),
    .LINREG1_PIN_ENABLE(pins[2]), .LINREG2_PIN_ENABLE(pins[3]), .VIN_OK(VIN_OK),
    .BUCK1_SENSE(sns), .BUCK2_SENSE(sns), .REG_ON(REG_ON), .BUCK1_HS_ON(hs1), .BUCK1_LS_ON(ls1),
    .BUCK2_HS_ON(), .BUCK2_LS_ON(), .SKIP_MODE(skip), .BUCK1_ILIMIT_MA(lim1),
    .BUCK2_ILIMIT_MA(lim2), .BUCK1_VOUT(), .BUCK2_VOUT());
  rps_host_model host (.vin_ok(VIN_OK), .want(want), .pins(pins));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic finish_test();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // one idle edge after release, so back-to-back calls never reassign PSEL
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] e);
    int n;
    if (!wr) expq.push_back(e);
    PSEL <= 1'h1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'h1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (!PREADY && n < 20);
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    if (!PREADY) begin
      errors++;
      finish_test();
    end
    @(posedge CLOCK);
  endtask : apb

  // first cycle each regulator reaches the trigger level, against d half-ms ticks
  task automatic seq(input logic lvl, input int d[4]);
    int t[4];
    t = '{-1, -1, -1, -1};
    SEQ_TRIGGER <= lvl;
    for (int c = 1; c <= L + 24 * H; c++) begin
      @(posedge CLOCK);
      for (int i = 0; i < 4; i++)
        if (t[i] < 0 && REG_ON[i] === lvl) t[i] = c;
    end
    for (int i = 0; i < 4; i++)
      chk("reg_on time", 33'h1, {32'h0, (t[i] - L - 4 - d[i] * H) inside {[-2:2]}});
  endtask : seq

  always @(posedge CLOCK)
    if (PSEL && PENABLE && PREADY && !PWRITE && expq.size() > 0)
      chk("apb read", expq.pop_front(), {PSLVERR, PRDATA});

  initial begin
    forever #5 CLOCK = ~CLOCK;
  end

  initial begin
    repeat (12) @(posedge CLOCK);
    RESETN <= 1'h1;
    @(posedge CLOCK);
    apb(1'h0, CTRL_OFS, 32'h0, 33'h00000000F);
    apb(1'h0, ON_DELAY_OFS, 32'h0, 33'h000004321);
    apb(1'h0, OFF_DELAY_OFS, 32'h0, 33'h000007777);
    apb(1'h0, 12'h020, 32'h0, 33'h100000000);
    repeat (6) begin
      en = 4'($random(seed));
      pv = 4'($random(seed));
      apb(1'h1, CTRL_OFS, {26'h0, pv[1:0], en}, '0);
      want <= pv;
      repeat (3) @(posedge CLOCK);
      chk("reg_on pins", {29'h0, en & pv}, {29'h0, REG_ON});
    end
    apb(1'h1, CTRL_OFS, 32'h0000000F, '0);
    want <= 4'h0;
    // pulse shorter than the filter must start nothing
    SEQ_TRIGGER <= 1'h1;
    repeat (L - 8) @(posedge CLOCK);
    apb(1'h0, STATUS_OFS, 32'h0, 33'h000000100);
    SEQ_TRIGGER <= 1'h0;
    repeat (L + 8 * H) @(posedge CLOCK);
    chk("reg_on glitch", 33'h0, {29'h0, REG_ON});
    apb(1'h1, VOUT_OFS, 32'h00003F15, '0);
    apb(1'h0, VOUT_OFS, 32'h0, 33'h000003F15);
    seq(1'h1, '{3, 4, 6, 12});
    chk("ilimit start", {11'h0, B1_MA0, B2_MA0}, {11'h0, lim1, lim2});
    apb(1'h0, VOUT_OFS, 32'h0, 33'h000001008);
    sns <= 8'h01;
    repeat (1400) @(posedge CLOCK);
    chk("skip early", 33'h0, {31'h0, skip});
    repeat (600) @(posedge CLOCK);
    chk("skip entry", 33'h3, {31'h0, skip});
    chk("ilimit step", {11'h0, B1_MA1, B2_MA1}, {11'h0, lim1, lim2});
    chk("switch sleep", 33'h0, {31'h0, hs1, ls1});
    sns <= 8'h41;
    repeat (2) @(posedge CLOCK);
    chk("switch wake", 33'h2, {31'h0, hs1, ls1});
    sns <= 8'h25;
    repeat (3) @(posedge CLOCK);
    chk("switch back", 33'h0, {31'h0, hs1, ls1});
    apb(1'h1, CTRL_OFS, 32'h0000001F, '0);
    @(posedge CLOCK);
    chk("skip forced", 33'h2, {31'h0, skip});
    sns <= 8'h10;
    repeat (3) @(posedge CLOCK);
    chk("skip low2", 33'h0, {31'h0, skip});
    sns <= 8'h00;
    want <= 4'($random(seed));
    repeat (5) @(posedge CLOCK);
    chk("reg_on trig high", 33'hF, {29'h0, REG_ON});
    VIN_OK <= 1'h0;
    repeat (3) @(posedge CLOCK);
    chk("reg_on vin low", 33'h0, {29'h0, REG_ON});
    chk("switch shut", 33'h1, {31'h0, hs1, ls1});
    VIN_OK <= 1'h1;
    want <= 4'h0;
    repeat (3) @(posedge CLOCK);
    seq(1'h0, '{3, 4, 6, 12});
    apb(1'h1, ON_DELAY_OFS, 32'h00005043, '0);
    apb(1'h0, ON_DELAY_OFS, 32'h0, 33'h000005043);
    seq(1'h1, '{6, 12, 2, 22});
    apb(1'h1, OFF_DELAY_OFS, 32'h00000135, '0);
    seq(1'h0, '{20, 4, 1, 0});
    // opposite edge while only linear regulator 1, the shortest on delay, is up
    SEQ_TRIGGER <= 1'h1;
    repeat (L + 4 * H) @(posedge CLOCK);
    chk("reg_on part", 33'h4, {29'h0, REG_ON});
    SEQ_TRIGGER <= 1'h0;
    repeat (L + 24 * H) @(posedge CLOCK);
    chk("reg_on abort", 33'h0, {29'h0, REG_ON});
    finish_test();
  end
endmodule : tb_top
